// >>> design/dpb_defines.svh
// parameter bank addresses, field positions and limits
`ifndef DPB_DEFINES_SVH
`define DPB_DEFINES_SVH
`define DPB_ADDR_ACCESS_INFO 16'h0118
`define DPB_ADDR_ACTION_STATUS 16'h1C08
`define DPB_ADDR_FRICTION 16'h2F0E
`define DPB_ADDR_LOAD 16'h2F10
`define DPB_ADDR_INERTIA 16'h2F18
`define DPB_ADDR_STORE 16'h3000
`define DPB_ADDR_LIMIT_CFG 16'h3002
`define DPB_INERTIA_MIN 16'h0001
`define DPB_INERTIA_MAX 16'hFFFF
`define DPB_INERTIA_RST 16'h0001
`define DPB_STANDSTILL_LIM 16'h0009
`define DPB_U16_MAX 16'hFFFF
`define DPB_S16_MIN 16'sh8000
`define DPB_S16_MAX 16'sh7FFF
`define DPB_CH_MAX 8'h1C
`define DPB_ST_MOTION_LO 6
`define DPB_ST_PG_LO 11
`endif

// >>> design/dpb_pkg.sv
// parameter bank types
package dpb_pkg;
   typedef enum logic [1:0] {PG_IDLE, PG_ACCEL, PG_DECEL, PG_CONST} dpb_pg_t;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dpb_state_t;
endpackage

// >>> design/dpb_store.sv
// persistent store image with registered read data
`timescale 1ns/100ps
`default_nettype none
module dpb_store #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   // refused while the design is elaborated, before any clock runs
   generate
      if (DEPTH < 2) begin : g_depth_check
         $error("dpb_store depth too small");
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule // dpb_store
`default_nettype wire

// >>> design/dpb_bank.sv
// drive parameter bank: access by unique parameter address
`timescale 1ns/100ps
`default_nettype none
`include "dpb_defines.svh"
// Overview of operation
// RULE1: unbounded parameters are limited to their data type's full range
// RULE2: read-only parameters answer reads; external writes never change them
// RULE3: read/write parameters accept both reads and writes
// RULE4: master must issue explicit store for values to survive power-off; here store writes do nothing, inertia is saved at each accepted tuning
// RULE5: decimals travel as scaled integers, all fractional digits included
// RULE6: each parameter has one address; accesses select by that address
// RULE7: some changes take effect only after a restart
// RULE8: access info low byte is 1 when channel holds exclusive access
// RULE9: access info high byte encodes the channel number, 0 to 28
// RULE10: each action status bit reads 1 when its condition is active
// RULE11: action status bits 0 to 4 flag error classes 0 to 4
// RULE12: bit 6 flags standstill, actual speed magnitude below 9
// RULE13: bit 7 positive motion, bit 8 negative motion
// RULE14: bits 9 and 10 selected by two limit-assignment configurations
// RULE15: bits 11,12,13 flag generator idle, decelerating, constant speed
// RULE16: inertia result unsigned, read-only, persistent, 0.1 to 6553.5
// RULE17: friction result unsigned 16-bit read-only, 0.01 A steps
// RULE18: load result signed 16-bit read-only, 0.01 A steps
// RULE19: reserved status bits 5 and 15 read zero
// RULE20: out-of-range writes are rejected; stored value unchanged
module dpb_bank (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [15:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   output logic RSP_VALID,
   output logic RSP_ERR,
   output logic [15:0] RSP_RDATA,
   input wire logic [7:0] CH_ID,
   input wire logic CH_EXCL,
   input wire logic [4:0] ERR_CLASS,
   input wire logic signed [15:0] SPEED_ACT,
   input wire logic [1:0] PG_STATE,
   input wire logic [3:0] LIMIT_COND,
   input wire logic AT_DONE,
   input wire logic [15:0] AT_INERTIA,
   input wire logic [15:0] AT_FRICTION,
   input wire logic signed [15:0] AT_LOAD,
   output logic [1:0] PROFILE_LIMIT_SEL,
   output logic [1:0] STANDARD_LIMIT_SEL
);
   logic [15:0] access_channel_info_r;
   logic [15:0] action_status_word_r;
   logic [15:0] friction_torque_result_r;
   logic signed [15:0] load_torque_result_r;
   logic [15:0] total_inertia_result_r;
   logic [3:0] limit_cfg_r;
   logic [15:0] rdata_nxt;
   logic hit_nxt;
   logic ro_nxt;
   logic rsp_valid_r;
   logic rsp_err_r;
   logic [15:0] rsp_rdata_r;
   logic inertia_ok;
   logic store_wr;
   logic [15:0] store_rd;
   logic boot_r;
   logic boot_load_r;
   dpb_pkg::dpb_pg_t pg;
   logic [15:0] speed_abs;

   assign pg = dpb_pkg::dpb_pg_t'(PG_STATE);
   assign speed_abs = SPEED_ACT[15] ? 16'(-SPEED_ACT) : SPEED_ACT;

   // access info: channel in high byte, exclusive flag in low byte
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         access_channel_info_r <= 16'h0000;
      end else begin
         access_channel_info_r <= {
            (CH_ID > `DPB_CH_MAX) ? 8'h00 : CH_ID, // [RULE9]
            7'h00, CH_EXCL}; // [RULE8]
      end
   end

   // status word rebuilt every cycle, reserved bits forced low
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         action_status_word_r <= 16'h0000;
      end else begin
         action_status_word_r[4:0] <= ERR_CLASS; // [RULE10] [RULE11]
         action_status_word_r[5] <= 1'b0; // [RULE19]
         action_status_word_r[`DPB_ST_MOTION_LO] <=
            speed_abs < `DPB_STANDSTILL_LIM; // [RULE12]
         action_status_word_r[7] <= !SPEED_ACT[15]
            && SPEED_ACT != 16'sh0000; // [RULE13]
         action_status_word_r[8] <= SPEED_ACT[15]; // [RULE13]
         action_status_word_r[9] <= LIMIT_COND[limit_cfg_r[1:0]]; // [RULE14]
         action_status_word_r[10] <= LIMIT_COND[limit_cfg_r[3:2]]; // [RULE14]
         action_status_word_r[`DPB_ST_PG_LO] <=
            pg == dpb_pkg::PG_IDLE; // [RULE15]
         action_status_word_r[12] <= pg == dpb_pkg::PG_DECEL; // [RULE15]
         action_status_word_r[13] <= pg == dpb_pkg::PG_CONST; // [RULE15]
         action_status_word_r[14] <= 1'b0;
         action_status_word_r[15] <= 1'b0; // [RULE19]
      end
   end

   // inertia must lie in 1..65535 tenths; zero from tuning is refused
   assign inertia_ok = AT_INERTIA >= `DPB_INERTIA_MIN; // [RULE16] [RULE20]
   assign store_wr = AT_DONE && inertia_ok;

   // autotuning results: only the internal tuner writes them
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         friction_torque_result_r <= 16'h0000;
         load_torque_result_r <= 16'sh0000;
      end else if (AT_DONE) begin
         friction_torque_result_r <= AT_FRICTION; // [RULE17] [RULE5]
         load_torque_result_r <= AT_LOAD; // [RULE18] [RULE5]
      end
   end

   // inertia is persistent: reloaded from the store image after restart
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         boot_r <= 1'b1;
         boot_load_r <= 1'b0;
      end else begin
         boot_r <= 1'b0;
         boot_load_r <= boot_r;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         total_inertia_result_r <= `DPB_INERTIA_RST;
      end else if (store_wr) begin
         total_inertia_result_r <= AT_INERTIA; // [RULE16]
      end else if (boot_load_r && store_rd >= `DPB_INERTIA_MIN) begin
         total_inertia_result_r <= store_rd; // [RULE16]
      end
   end

   dpb_store #(.WIDTH(16), .DEPTH(4)) u_store (
      .clk(CORE_CLK),
      .wr_en(store_wr),
      .wr_addr(2'h0),
      .wr_data(AT_INERTIA),
      .rd_addr(2'h0),
      .rd_data(store_rd)
   );

   // limit assignment config is read/write; new selection only after restart
   logic [3:0] limit_pend_r;
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         limit_cfg_r <= limit_pend_r; // [RULE7]
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (REQ_VALID && REQ_WRITE && REQ_ADDR == `DPB_ADDR_LIMIT_CFG
          && REQ_WDATA[15:4] == 12'h000) begin
         limit_pend_r <= REQ_WDATA[3:0]; // [RULE3] [RULE20]
      end
   end
   assign PROFILE_LIMIT_SEL = limit_cfg_r[1:0];
   assign STANDARD_LIMIT_SEL = limit_cfg_r[3:2];

   // address decode
   always_comb begin
      rdata_nxt = 16'h0000;
      hit_nxt = 1'b1;
      ro_nxt = 1'b1;
      case (REQ_ADDR)
         `DPB_ADDR_ACCESS_INFO: rdata_nxt = access_channel_info_r; // [RULE6]
         `DPB_ADDR_ACTION_STATUS: rdata_nxt = action_status_word_r; // [RULE6]
         `DPB_ADDR_FRICTION: rdata_nxt = friction_torque_result_r;
         `DPB_ADDR_LOAD: rdata_nxt = load_torque_result_r;
         `DPB_ADDR_INERTIA: rdata_nxt = total_inertia_result_r;
         `DPB_ADDR_LIMIT_CFG: begin
            rdata_nxt = {12'h000, limit_pend_r};
            ro_nxt = 1'b0; // [RULE3]
         end
         `DPB_ADDR_STORE: ro_nxt = 1'b0; // [RULE4]
         default: hit_nxt = 1'b0;
      endcase
   end

   // one-cycle answer; writes to read-only or unknown addresses flag error
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rsp_valid_r <= 1'b0;
         rsp_err_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
      end else begin
         rsp_valid_r <= REQ_VALID;
         rsp_err_r <= REQ_VALID && (!hit_nxt || (REQ_WRITE && ro_nxt)
            || (REQ_WRITE && REQ_ADDR == `DPB_ADDR_LIMIT_CFG
                && REQ_WDATA[15:4] != 12'h000)); // [RULE2] [RULE20] [RULE1]
         rsp_rdata_r <= (REQ_VALID && !REQ_WRITE) ? rdata_nxt : 16'h0000;
      end
   end
   assign RSP_VALID = rsp_valid_r;
   assign RSP_ERR = rsp_err_r;
   assign RSP_RDATA = rsp_rdata_r;

   property p_rsp_one;
      @(posedge CORE_CLK) disable iff (RST)
         REQ_VALID |=> RSP_VALID;
   endproperty
   a_rsp_one: assert property (p_rsp_one) else $error("no answer"); // [RULE6]

   property p_ro_write;
      @(posedge CORE_CLK) disable iff (RST)
         REQ_VALID && REQ_WRITE && REQ_ADDR == `DPB_ADDR_ACTION_STATUS
         |=> RSP_ERR;
   endproperty
   a_ro_write: assert property (p_ro_write) // [RULE2]
      else $error("ro write ok");

   property p_reserved;
      @(posedge CORE_CLK) disable iff (RST)
         action_status_word_r[5] == 1'b0 && action_status_word_r[15] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) // [RULE19]
      else $error("reserved set");

   property p_still;
      @(posedge CORE_CLK) disable iff (RST)
         !RST && speed_abs < `DPB_STANDSTILL_LIM
         |=> action_status_word_r[6];
   endproperty
   a_still: assert property (p_still) else $error("standstill"); // [RULE12]

   property p_err_cls;
      @(posedge CORE_CLK) disable iff (RST)
         !RST |=> action_status_word_r[4:0] == $past(ERR_CLASS);
   endproperty
   a_err_cls: assert property (p_err_cls) else $error("err class"); // [RULE11]

   property p_dir;
      @(posedge CORE_CLK) disable iff (RST)
         !(action_status_word_r[7] && action_status_word_r[8]);
   endproperty
   a_dir: assert property (p_dir) else $error("both directions"); // [RULE13]

   property p_inertia_min;
      @(posedge CORE_CLK) disable iff (RST)
         boot_load_r == 1'b0 |-> total_inertia_result_r >= `DPB_INERTIA_MIN;
   endproperty
   a_inertia_min: assert property (p_inertia_min) // [RULE16]
      else $error("inertia 0");

   sequence s_cfg_wr;
      REQ_VALID && REQ_WRITE && REQ_ADDR == `DPB_ADDR_LIMIT_CFG;
   endsequence
   property p_cfg_late;
      @(posedge CORE_CLK) disable iff (RST)
         s_cfg_wr |=> $stable(limit_cfg_r);
   endproperty
   a_cfg_late: assert property (p_cfg_late) else $error("cfg early"); // [RULE7]

   property p_pg;
      @(posedge CORE_CLK) disable iff (RST)
         !RST && pg == dpb_pkg::PG_DECEL |=> action_status_word_r[12]
         && !action_status_word_r[13];
   endproperty
   a_pg: assert property (p_pg) else $error("pg decel"); // [RULE15]

   property p_unmapped;
      @(posedge CORE_CLK) disable iff (RST)
         REQ_VALID && !hit_nxt |=> RSP_ERR && RSP_RDATA == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) // [RULE6]
      else $error("unmapped address accepted");

   // a refused selection must leave the pending value untouched
   property p_cfg_range;
      @(posedge CORE_CLK) disable iff (RST)
         s_cfg_wr ##0 REQ_WDATA[15:4] != 12'h000
         |=> RSP_ERR && limit_pend_r == $past(limit_pend_r);
   endproperty
   a_cfg_range: assert property (p_cfg_range) // [RULE20]
      else $error("cfg range");

   property p_cfg_take;
      @(posedge CORE_CLK) disable iff (RST)
         s_cfg_wr ##0 REQ_WDATA[15:4] == 12'h000
         |=> !RSP_ERR && limit_pend_r == $past(REQ_WDATA[3:0]);
   endproperty
   a_cfg_take: assert property (p_cfg_take) // [RULE3]
      else $error("cfg write lost");

   property p_inertia_keep;
      @(posedge CORE_CLK) disable iff (RST)
         !RST && AT_DONE && AT_INERTIA == 16'h0000 && !boot_load_r
         |=> $stable(total_inertia_result_r);
   endproperty
   a_inertia_keep: assert property (p_inertia_keep) // [RULE20]
      else $error("inertia 0 taken");

   // restart reloads the stored inertia two edges after release
   sequence s_restart;
      RST ##1 !RST;
   endsequence
   sequence s_boot_load;
      !RST && boot_load_r && !store_wr && store_rd >= `DPB_INERTIA_MIN;
   endsequence
   property p_persist;
      @(posedge CORE_CLK)
         s_restart ##1 s_boot_load
         |=> total_inertia_result_r == $past(store_rd);
   endproperty
   a_persist: assert property (p_persist) // [RULE16]
      else $error("inertia not restored");

   property p_chan;
      @(posedge CORE_CLK) disable iff (RST)
         !RST && CH_ID <= `DPB_CH_MAX
         |=> access_channel_info_r[15:8] == $past(CH_ID);
   endproperty
   a_chan: assert property (p_chan) // [RULE9]
      else $error("channel code");

   property p_dir_pos;
      @(posedge CORE_CLK) disable iff (RST)
         !RST && SPEED_ACT > 16'sh0000
         |=> action_status_word_r[7] && !action_status_word_r[8];
   endproperty
   a_dir_pos: assert property (p_dir_pos) // [RULE13]
      else $error("positive motion");
endmodule // dpb_bank
`default_nettype wire

// >>> bench/dpb_master_model.sv
// fieldbus master model issuing one-word parameter accesses
`timescale 1ns/100ps
`default_nettype none
module dpb_master_model (
   input wire logic clk,
   input wire logic rsp_valid,
   input wire logic rsp_err,
   input wire logic [15:0] rsp_rdata,
   output logic req_valid,
   output logic req_write,
   output logic [15:0] req_addr,
   output logic [15:0] req_wdata
);
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 16'h0000;
   end
   // whole 16-bit word per access, selected by its address
   task automatic access(input logic w, input logic [15:0] a,
         input logic [15:0] d, output logic e, output logic [15:0] q);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      // released lines show no stale value
      req_valid <= 1'b0;
      req_write <= ~w;
      req_addr <= ~a;
      req_wdata <= ~d;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 8);
      e = (rsp_valid === 1'b1) ? rsp_err : 1'bx;
      q = rsp_rdata;
   endtask
endmodule // dpb_master_model
`default_nettype wire

// >>> bench/drive_parameter_bank_tb_top.sv
// self-checking bench of the drive parameter bank
`timescale 1ns/100ps
`default_nettype none
module drive_parameter_bank_tb_top;
   typedef struct packed {
      logic w;
      logic [15:0] a;
      logic [15:0] d;
      logic e;
      logic [15:0] q;
   } dpb_row_t;
   logic CORE_CLK, RST, REQ_VALID, REQ_WRITE, RSP_VALID, RSP_ERR;
   logic CH_EXCL, AT_DONE;
   logic [15:0] REQ_ADDR, REQ_WDATA, RSP_RDATA, AT_INERTIA, AT_FRICTION;
   logic [7:0] CH_ID;
   logic [4:0] ERR_CLASS;
   logic signed [15:0] SPEED_ACT, AT_LOAD;
   logic [1:0] PG_STATE, PROFILE_LIMIT_SEL, STANDARD_LIMIT_SEL;
   logic [3:0] LIMIT_COND;
   int fails = 0;
   int checks = 0;
   dpb_row_t rows [10];
   dpb_bank i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
      .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
      .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR), .RSP_RDATA(RSP_RDATA),
      .CH_ID(CH_ID), .CH_EXCL(CH_EXCL), .ERR_CLASS(ERR_CLASS),
      .SPEED_ACT(SPEED_ACT), .PG_STATE(PG_STATE), .LIMIT_COND(LIMIT_COND),
      .AT_DONE(AT_DONE), .AT_INERTIA(AT_INERTIA), .AT_FRICTION(AT_FRICTION),
      .AT_LOAD(AT_LOAD), .PROFILE_LIMIT_SEL(PROFILE_LIMIT_SEL),
      .STANDARD_LIMIT_SEL(STANDARD_LIMIT_SEL));
   dpb_master_model i_master (.clk(CORE_CLK), .rsp_valid(RSP_VALID),
      .rsp_err(RSP_ERR), .rsp_rdata(RSP_RDATA), .req_valid(REQ_VALID),
      .req_write(REQ_WRITE), .req_addr(REQ_ADDR), .req_wdata(REQ_WDATA));
   initial begin
      CORE_CLK = 1'b0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   task automatic summarize;
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_data(string n, logic [15:0] x, logic [15:0] g);
      checks++;
      if (g !== x) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic chk_flag(string n, logic x, logic g);
      checks++;
      if (g !== x) begin
         fails++;
         $display("ERROR %s expected %b seen %b", n, x, g);
      end
   endtask
   task automatic acc(logic w, logic [15:0] a, logic [15:0] d, logic ee,
         logic [15:0] eq);
      logic e;
      logic [15:0] q;
      i_master.access(w, a, d, e, q);
      chk_flag("rsp_err", ee, e);
      if (!ee) chk_data("rsp_rdata", eq, q);
   endtask
   task automatic step(int n);
      repeat (n) @(posedge CORE_CLK);
   endtask
   initial begin
      step(2000);
      fails++;
      summarize();
   end
   initial begin
      RST = 1'b1;
      CH_ID = 8'h04;
      CH_EXCL = 1'b1;
      ERR_CLASS = 5'h15;
      SPEED_ACT = 16'sh0064;
      PG_STATE = 2'h2;
      LIMIT_COND = 4'h1;
      AT_DONE = 1'b0;
      AT_INERTIA = 16'h0000;
      AT_FRICTION = 16'h0000;
      AT_LOAD = 16'sh0000;
      rows = '{
         '{0, 16'h0118, 16'h0000, 0, 16'h0401},
         '{0, 16'h1C08, 16'h0000, 0, 16'h1295},
         '{0, 16'h2F18, 16'h0000, 0, 16'h0001},
         '{1, 16'h2F18, 16'h0005, 1, 16'h0000},
         '{1, 16'h1C08, 16'h0000, 1, 16'h0000},
         '{1, 16'h0118, 16'h0000, 1, 16'h0000},
         '{0, 16'h0000, 16'h0000, 1, 16'h0000},
         '{1, 16'h3002, 16'h0010, 1, 16'h0000},
         '{1, 16'h3002, 16'h000B, 0, 16'h0000},
         '{1, 16'h3000, 16'h0000, 0, 16'h0000}};
      step(6);
      RST <= 1'b0;
      step(1);
      acc(1, 16'h3002, 16'h0004, 0, 16'h0000);
      acc(1, 16'h3000, 16'h0000, 0, 16'h0000);
      RST <= 1'b1;
      step(2);
      RST <= 1'b0;
      step(1);
      chk_data("prof_sel", 16'h0000, {14'h0, PROFILE_LIMIT_SEL});
      chk_data("std_sel", 16'h0001, {14'h0, STANDARD_LIMIT_SEL});
      foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d, rows[i].e,
         rows[i].q);
      // pending selection stays inactive until the next restart
      chk_data("prof_sel", 16'h0000, {14'h0, PROFILE_LIMIT_SEL});
      acc(0, 16'h3002, 16'h0000, 0, 16'h000B);
      AT_DONE <= 1'b1;
      AT_INERTIA <= 16'h1234;
      AT_FRICTION <= 16'hFFFF;
      AT_LOAD <= 16'sh8000;
      step(1);
      AT_DONE <= 1'b0;
      step(1);
      acc(0, 16'h2F18, 16'h0000, 0, 16'h1234);
      acc(0, 16'h2F0E, 16'h0000, 0, 16'hFFFF);
      acc(0, 16'h2F10, 16'h0000, 0, 16'h8000);
      AT_DONE <= 1'b1;
      AT_INERTIA <= 16'h0000;
      step(1);
      AT_DONE <= 1'b0;
      step(1);
      acc(0, 16'h2F18, 16'h0000, 0, 16'h1234);
      ERR_CLASS <= 5'h00;
      SPEED_ACT <= -16'sd8;
      PG_STATE <= 2'h0;
      CH_ID <= 8'h1D;
      CH_EXCL <= 1'b0;
      step(2);
      acc(0, 16'h1C08, 16'h0000, 0, 16'h0B40);
      acc(0, 16'h0118, 16'h0000, 0, 16'h0000);
      LIMIT_COND <= 4'h2;
      step(2);
      acc(0, 16'h1C08, 16'h0000, 0, 16'h0D40);
      SPEED_ACT <= 16'sd9;
      PG_STATE <= 2'h3;
      LIMIT_COND <= 4'h0;
      step(2);
      acc(0, 16'h1C08, 16'h0000, 0, 16'h2080);
      // restart: pending selection goes live, stored inertia comes back
      RST <= 1'b1;
      step(2);
      RST <= 1'b0;
      step(2);
      chk_data("prof_sel", 16'h0003, {14'h0, PROFILE_LIMIT_SEL});
      chk_data("std_sel", 16'h0002, {14'h0, STANDARD_LIMIT_SEL});
      acc(0, 16'h2F18, 16'h0000, 0, 16'h1234);
      summarize();
   end
endmodule // drive_parameter_bank_tb_top
`default_nettype wire
